// ---- verilog/esc_pkg.sv ----
/*
 * shared constants for the nvm status/control register pair:
 * register offsets, field positions, reset values and sequencer states.
 * assumes an 8-bit register port in the core's extended sfr space.
 */
package esc_pkg;

    localparam logic [7:0] ESC_STATUS_ADDR = 8'hE1;
    localparam logic [7:0] ESC_CONTROL_ADDR = 8'hE2;

    localparam logic [7:0] ESC_STATUS_RESET = 8'h00;
    localparam logic [7:0] ESC_CONTROL_RESET = 8'h00;
    localparam logic [7:0] ESC_UNMAPPED_DATA = 8'h00;

    localparam int ESC_BANK_LSB = 0;
    localparam int ESC_BANK_MSB = 2;
    localparam int ESC_WRITE_BUSY_BIT = 3;
    localparam int ESC_CACHE_BUSY_BIT = 4;
    localparam int ESC_WRITE_OK_BIT = 5;
    localparam int ESC_CRC_ERR_BIT = 6;
    localparam int ESC_TRIM_ERR_BIT = 7;

    localparam int ESC_REQUEST_BIT = 0;

    localparam logic [2:0] ESC_BANK_RESET = 3'h0;
    localparam logic [2:0] ESC_BANK_LAST = 3'h5;

    typedef enum logic [1:0] {
        ESC_SEQ_IDLE,
        ESC_SEQ_START,
        ESC_SEQ_WAIT
    } esc_seq_state_t;

endpackage

// ---- verilog/esc_write_seq.sv ----
/*
 * bank 0 program sequencer: turns a request into a start pulse towards
 * the nvm macro, keeps the busy flag until the macro reports done and
 * latches the outcome as the success flag.
 * assumes done_in is a one-cycle pulse that follows start_out.
 */
`timescale 1ns/1ps

module esc_write_seq
    import esc_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic req_in,
    input wire logic done_in,
    input wire logic ok_in,
    output logic start_out,
    output logic busy_out,
    output logic success_out
);

    esc_seq_state_t state_q;
    logic busy_q;
    logic success_q;
    logic accept;

    // a request while busy is dropped; software must poll busy first
    assign accept = req_in && (state_q == ESC_SEQ_IDLE);

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_q <= ESC_SEQ_IDLE;
        end else begin
            case (state_q)
                ESC_SEQ_IDLE: begin
                    if (accept) begin
                        state_q <= ESC_SEQ_START;
                    end
                end
                ESC_SEQ_START: begin
                    state_q <= ESC_SEQ_WAIT;
                end
                ESC_SEQ_WAIT: begin
                    if (done_in) begin
                        state_q <= ESC_SEQ_IDLE;
                    end
                end
                default: begin
                    state_q <= ESC_SEQ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            busy_q <= 1'b0;
        end else if (accept) begin
            busy_q <= 1'b1; // R2
        end else if (state_q == ESC_SEQ_WAIT && done_in) begin
            busy_q <= 1'b0; // R2
        end
    end

    // cleared when a new operation starts so a stale pass cannot be read
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            success_q <= 1'b0;
        end else if (accept) begin
            success_q <= 1'b0; // R4
        end else if (state_q == ESC_SEQ_WAIT && done_in) begin
            success_q <= ok_in; // R4
        end
    end

    assign start_out = (state_q == ESC_SEQ_START); // R7
    assign busy_out = busy_q;
    assign success_out = success_q;

endmodule

// ---- verilog/esc_regs_top.sv ----
/*
 * nvm status and control registers for the embedded core.
 * holds the status register (bank, busy flags, success, crc and trim
 * errors) and the control register whose bit 0 starts a bank 0 program.
 * assumes the core's sfr port: one-cycle strobes, read data the cycle
 * after the read strobe, and status levels synchronous to clk_in.
 */
// Functional notes
// R1: status bits 2:0 show the selected bank, 000..101 for banks 0..5.
// R2: write busy flag reads 1 while a program operation runs, else 0.
// R3: cache load busy flag reads 1 while data is copied to cache.
// R4: write success flag reads 1 after a correctly completed program.
// R5: status bit 6 reads 1 when the stored contents fail crc.
// R6: status bit 7 reads 1 when internal trim values are corrupted.
// R7: writing 1 to control bit 0 starts a bank 0 program; 0 does nothing.
// R8: software waits for busy to clear before trusting success or re-requesting.
`timescale 1ns/1ps

module esc_regs_top
    import esc_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic [2:0] bank_code_in,
    input wire logic cache_load_busy_in,
    input wire logic crc_error_in,
    input wire logic trim_error_in,
    input wire logic write_done_in,
    input wire logic write_ok_in,
    output logic write_start_out
);

    function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
        hit = (a == reg_addr);
    endfunction

    logic [2:0] selected_bank_code_q;
    logic cache_load_busy_flag_q;
    logic crc_error_flag_q;
    logic trim_error_flag_q;
    logic [7:0] nvm_control_q;
    logic [7:0] rdata_q;
    logic [7:0] nvm_status;
    logic core_write_request;
    logic write_busy_flag;
    logic write_success_flag;

    // live levels from the nvm macro, registered so every read sees flops
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            selected_bank_code_q <= ESC_BANK_RESET;
        end else begin
            selected_bank_code_q <= bank_code_in; // R1
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            cache_load_busy_flag_q <= 1'b0;
        end else begin
            cache_load_busy_flag_q <= cache_load_busy_in; // R3
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            crc_error_flag_q <= 1'b0;
            trim_error_flag_q <= 1'b0;
        end else begin
            crc_error_flag_q <= crc_error_in; // R5
            trim_error_flag_q <= trim_error_in; // R6
        end
    end

    // all eight control bits store and read back; only bit 0 acts
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            nvm_control_q <= ESC_CONTROL_RESET;
        end else if (wr_in && hit(addr_in, ESC_CONTROL_ADDR)) begin
            nvm_control_q <= wdata_in;
        end
    end

    // the write itself is the trigger, so rewriting 1 starts again once idle
    assign core_write_request = wr_in && hit(addr_in, ESC_CONTROL_ADDR)
                                && wdata_in[ESC_REQUEST_BIT]; // R7

    esc_write_seq u_write_seq (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .req_in(core_write_request),
        .done_in(write_done_in),
        .ok_in(write_ok_in),
        .start_out(write_start_out),
        .busy_out(write_busy_flag),
        .success_out(write_success_flag)
    );

    always_comb begin
        nvm_status = ESC_STATUS_RESET;
        nvm_status[ESC_BANK_MSB:ESC_BANK_LSB] = selected_bank_code_q; // R1
        nvm_status[ESC_WRITE_BUSY_BIT] = write_busy_flag; // R2
        nvm_status[ESC_CACHE_BUSY_BIT] = cache_load_busy_flag_q; // R3
        nvm_status[ESC_WRITE_OK_BIT] = write_success_flag; // R4
        nvm_status[ESC_CRC_ERR_BIT] = crc_error_flag_q; // R5
        nvm_status[ESC_TRIM_ERR_BIT] = trim_error_flag_q; // R6
    end

    // read data stands only in the cycle after the strobe, zero otherwise
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            rdata_q <= ESC_UNMAPPED_DATA;
        end else if (rd_in && hit(addr_in, ESC_STATUS_ADDR)) begin
            rdata_q <= nvm_status;
        end else if (rd_in && hit(addr_in, ESC_CONTROL_ADDR)) begin
            rdata_q <= nvm_control_q;
        end else begin
            rdata_q <= ESC_UNMAPPED_DATA;
        end
    end

    assign rdata_out = rdata_q;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    sequence s_status_read;
        rd_in && addr_in == ESC_STATUS_ADDR;
    endsequence

    sequence s_control_read;
        rd_in && addr_in == ESC_CONTROL_ADDR;
    endsequence

    sequence s_control_write;
        wr_in && addr_in == ESC_CONTROL_ADDR;
    endsequence

    sequence s_request;
        wr_in && addr_in == ESC_CONTROL_ADDR && wdata_in[ESC_REQUEST_BIT] && !write_busy_flag;
    endsequence

    // a request that lands while the sequencer is still working
    sequence s_busy_request;
        wr_in && addr_in == ESC_CONTROL_ADDR && wdata_in[ESC_REQUEST_BIT] && write_busy_flag
            && !write_done_in;
    endsequence

    // busy without the start pulse means the sequencer waits for done
    sequence s_done_wait;
        write_busy_flag && !write_start_out && write_done_in;
    endsequence

    // the input flops still hold reset values one cycle after release
    property p_bank_read;
        !reset_in ##1 s_status_read
            |=> rdata_out[ESC_BANK_MSB:ESC_BANK_LSB] == $past(bank_code_in, 2);
    endproperty
    a_bank_read: assert property (p_bank_read) // R1
        else $error("bank code read back wrong");

    property p_busy_span;
        s_request |=> write_busy_flag && !write_success_flag && write_start_out
            ##1 write_busy_flag && !write_start_out;
    endproperty
    a_busy_span: assert property (p_busy_span) // R2
        else $error("busy flag or start pulse missing after request");

    property p_busy_clear;
        s_done_wait |=> !write_busy_flag;
    endproperty
    a_busy_clear: assert property (p_busy_clear) // R2
        else $error("busy flag did not clear on done");

    property p_busy_hold;
        write_busy_flag && !write_done_in |=> write_busy_flag;
    endproperty
    a_busy_hold: assert property (p_busy_hold) // R2
        else $error("busy flag dropped before done");

    property p_idle_quiet;
        !write_busy_flag && !(wr_in && addr_in == ESC_CONTROL_ADDR
            && wdata_in[ESC_REQUEST_BIT]) |=> !write_busy_flag && !write_start_out;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) // R2
        else $error("busy flag or start pulse without a request");

    property p_busy_refuse;
        s_busy_request |=> write_busy_flag && !write_start_out;
    endproperty
    a_busy_refuse: assert property (p_busy_refuse) // R2
        else $error("request while busy was not dropped");

    property p_busy_read;
        s_status_read |=> rdata_out[ESC_WRITE_BUSY_BIT] == $past(write_busy_flag);
    endproperty
    a_busy_read: assert property (p_busy_read) // R2
        else $error("busy flag read back wrong");

    property p_cache_busy;
        !reset_in && cache_load_busy_in ##1 s_status_read
            |=> rdata_out[ESC_CACHE_BUSY_BIT];
    endproperty
    a_cache_busy: assert property (p_cache_busy) // R3
        else $error("cache load busy not reported");

    property p_cache_idle;
        !reset_in && !cache_load_busy_in ##1 s_status_read
            |=> !rdata_out[ESC_CACHE_BUSY_BIT];
    endproperty
    a_cache_idle: assert property (p_cache_idle) // R3
        else $error("cache load busy reported while idle");

    property p_success;
        s_done_wait |=> write_success_flag == $past(write_ok_in) && !write_start_out;
    endproperty
    a_success: assert property (p_success) // R4
        else $error("success flag does not match outcome");

    property p_no_stale_success;
        write_busy_flag |-> !write_success_flag;
    endproperty
    a_no_stale_success: assert property (p_no_stale_success) // R4
        else $error("success flag set while a program runs");

    property p_success_read;
        s_status_read |=> rdata_out[ESC_WRITE_OK_BIT] == $past(write_success_flag);
    endproperty
    a_success_read: assert property (p_success_read) // R4
        else $error("success flag read back wrong");

    property p_crc;
        !reset_in && crc_error_in ##1 s_status_read |=> rdata_out[ESC_CRC_ERR_BIT];
    endproperty
    a_crc: assert property (p_crc) // R5
        else $error("crc error not reported");

    property p_crc_clear;
        !reset_in && !crc_error_in ##1 s_status_read |=> !rdata_out[ESC_CRC_ERR_BIT];
    endproperty
    a_crc_clear: assert property (p_crc_clear) // R5
        else $error("crc error reported while crc good");

    property p_trim;
        !reset_in && !trim_error_in ##1 s_status_read |=> !rdata_out[ESC_TRIM_ERR_BIT];
    endproperty
    a_trim: assert property (p_trim) // R6
        else $error("trim error reported while trim good");

    property p_trim_set;
        !reset_in && trim_error_in ##1 s_status_read |=> rdata_out[ESC_TRIM_ERR_BIT];
    endproperty
    a_trim_set: assert property (p_trim_set) // R6
        else $error("trim error not reported");

    // checked one cycle only, so a request right behind it stays legal
    property p_write_zero;
        wr_in && addr_in == ESC_CONTROL_ADDR && !wdata_in[ESC_REQUEST_BIT] && !write_busy_flag
            |=> !write_busy_flag && !write_start_out;
    endproperty
    a_write_zero: assert property (p_write_zero) // R7
        else $error("writing zero started a program");

    property p_start_pulse;
        write_start_out |=> !write_start_out && write_busy_flag;
    endproperty
    a_start_pulse: assert property (p_start_pulse) // R7
        else $error("start pulse longer than one cycle");

    property p_start_cause;
        write_start_out |-> $past(wr_in) && $past(addr_in) == ESC_CONTROL_ADDR
            && $past(wdata_in[ESC_REQUEST_BIT]) && !$past(write_busy_flag);
    endproperty
    a_start_cause: assert property (p_start_cause) // R7
        else $error("start pulse without an accepted request");

    property p_control_write;
        s_control_write |=> nvm_control_q == $past(wdata_in);
    endproperty
    a_control_write: assert property (p_control_write) // R7
        else $error("control write did not land");

    property p_control_read;
        s_control_read |=> rdata_out == $past(nvm_control_q);
    endproperty
    a_control_read: assert property (p_control_read) // R7
        else $error("control read back wrong");

    property p_write_refused;
        wr_in && addr_in != ESC_CONTROL_ADDR |=> $stable(nvm_control_q) && !write_start_out;
    endproperty
    a_write_refused: assert property (p_write_refused) // R7
        else $error("write to another address changed control");

    property p_read_idle;
        !rd_in |=> rdata_out == ESC_UNMAPPED_DATA;
    endproperty
    a_read_idle: assert property (p_read_idle)
        else $error("read data stood longer than one cycle");

    property p_unmapped;
        rd_in && addr_in != ESC_STATUS_ADDR && addr_in != ESC_CONTROL_ADDR
            |=> rdata_out == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read returned data");

endmodule

// ---- bench/esc_nvm_model.sv ----
/*
 * behavioural nvm macro: answers a start pulse with a done pulse after
 * DELAY cycles, carrying the outcome commanded by the bench.
 * assumes start_in is a one-cycle pulse from the register block.
 */
`timescale 1ns/1ps

module esc_nvm_model #(
    parameter int DELAY = 10
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic start_in,
    input wire logic ok_cmd_in,
    output logic done_out,
    output logic ok_out
);
    logic [7:0] cnt_q;

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            cnt_q <= 8'h00;
        end else if (start_in) begin
            cnt_q <= 8'(DELAY);
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end

    assign done_out = (cnt_q == 8'h01);
    // outcome is only valid with done; show the opposite otherwise
    assign ok_out = done_out ? ok_cmd_in : ~ok_cmd_in;
endmodule

// ---- bench/tb.sv ----
/*
 * self-checking bench for the nvm status/control registers.
 * assumes the sfr port of esc_regs_top and the nvm model as far side.
 */
`timescale 1ns/1ps

module tb;
    import esc_pkg::*;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic ok_cmd = 1'b0;
    logic cache_load_busy_in = 1'b0;
    logic crc_error_in = 1'b0;
    logic trim_error_in = 1'b0;
    logic [2:0] bank_code_in = 3'h0;
    logic [7:0] addr_in = 8'h00;
    logic [7:0] wdata_in = 8'h00;
    logic [7:0] rdata_out;
    logic [7:0] v;
    logic write_done_in;
    logic write_ok_in;
    logic write_start_out;
    int miscompares = 0;
    int checks = 0;
    int starts = 0;
    // rows: {trim, crc, cache busy, bank code} beside the status they should read
    logic [13:0] rows [8] = '{14'h0000, 14'h0911, 14'h1242, 14'h2383, 14'h3CD4, 14'h0505,
        14'h1646, 14'h0F17};

    always #2 clk_in = ~clk_in;
    // counts high cycles, so a stretched pulse shows up too
    always @(posedge clk_in) if (write_start_out === 1'b1) starts <= starts + 1;

    esc_regs_top u_dut (.clk_in, .reset_in, .addr_in, .wdata_in, .wr_in, .rd_in,
        .rdata_out, .bank_code_in, .cache_load_busy_in, .crc_error_in,
        .trim_error_in, .write_done_in, .write_ok_in, .write_start_out);
    esc_nvm_model u_nvm (.clk_in(clk_in), .reset_in(reset_in), .start_in(write_start_out),
        .ok_cmd_in(ok_cmd), .done_out(write_done_in), .ok_out(write_ok_in));

    function automatic logic [7:0] st(logic busy, logic succ);
        return {trim_error_in, crc_error_in, succ, cache_load_busy_in, busy, bank_code_in};
    endfunction

    task automatic summarize;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic cmp(string n, logic [7:0] e, logic [7:0] s);
        checks++;
        if (s !== e) begin
            $display("mismatch %s expected %h seen %h", n, e, s);
            miscompares++;
        end
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask

    task automatic rd(logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask

    // bounded poll; running out counts as a mismatch and ends the run
    task automatic wait_idle;
        for (int i = 0; i < 60; i++) begin
            rd(ESC_STATUS_ADDR, v);
            if (v[ESC_WRITE_BUSY_BIT] === 1'b0) return;
        end
        miscompares++;
        summarize();
    endtask

    initial begin
        repeat (6) @(posedge clk_in);
        reset_in <= 1'b0;
        rd(ESC_STATUS_ADDR, v);
        cmp("status reset", ESC_STATUS_RESET, v);
        rd(ESC_CONTROL_ADDR, v);
        cmp("control reset", ESC_CONTROL_RESET, v);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_in);
            {trim_error_in, crc_error_in, cache_load_busy_in, bank_code_in} <= rows[i][13:8];
            rd(ESC_STATUS_ADDR, v);
            cmp("status row", rows[i][7:0], v);
        end
        wr(ESC_CONTROL_ADDR, 8'hA4);
        rd(ESC_CONTROL_ADDR, v);
        cmp("control rw", 8'hA4, v);
        cmp("start on zero", 8'h00, starts[7:0]);
        wr(ESC_STATUS_ADDR, 8'hFF);
        rd(ESC_STATUS_ADDR, v);
        cmp("status ro", st(1'b0, 1'b0), v);
        @(posedge clk_in);
        #1 cmp("read gap", ESC_UNMAPPED_DATA, rdata_out);
        rd(8'h00, v);
        cmp("unmapped", ESC_UNMAPPED_DATA, v);
        ok_cmd <= 1'b1;
        wr(ESC_CONTROL_ADDR, 8'h01);
        rd(ESC_STATUS_ADDR, v);
        cmp("busy", st(1'b1, 1'b0), v);
        wr(ESC_CONTROL_ADDR, 8'h01);
        wait_idle();
        cmp("good", st(1'b0, 1'b1), v);
        cmp("one start", 8'h01, starts[7:0]);
        ok_cmd <= 1'b0;
        wr(ESC_CONTROL_ADDR, 8'h01);
        rd(ESC_STATUS_ADDR, v);
        cmp("success cleared", st(1'b1, 1'b0), v);
        wait_idle();
        cmp("bad", st(1'b0, 1'b0), v);
        cmp("two starts", 8'h02, starts[7:0]);
        ok_cmd <= 1'b1;
        wr(ESC_CONTROL_ADDR, 8'h01);
        @(posedge clk_in);
        reset_in <= 1'b1;
        @(posedge clk_in);
        reset_in <= 1'b0;
        rd(ESC_CONTROL_ADDR, v);
        cmp("control rereset", ESC_CONTROL_RESET, v);
        rd(ESC_STATUS_ADDR, v);
        cmp("status rereset", st(1'b0, 1'b0), v);
        wr(ESC_CONTROL_ADDR, 8'h01);
        wait_idle();
        cmp("good after reset", st(1'b0, 1'b1), v);
        cmp("four starts", 8'h04, starts[7:0]);
        summarize();
    end
endmodule
